// ### core/nvm_seq_pkg.sv
`default_nettype none
package nvm_seq_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] ADR_CTRL    = 16'h0760;
    localparam logic [15:0] ADR_LOW     = 16'h0762;
    localparam logic [15:0] ADR_UPPER   = 16'h0764;
    localparam logic [15:0] ADR_KEY     = 16'h0766;

    localparam int          BIT_WR      = 15;
    localparam int          BIT_WRITE_ALLOW = 14;
    localparam int          BIT_WRITE_ERROR = 13;
    localparam int          BIT_TERMINATED  = 8;
    localparam int          OP_MSB      = 6;
    localparam int          OP_EE_BIT   = 2;

    localparam logic [15:0] CTRL_RESET  = 16'h0000;
    localparam logic [15:0] ADDR_RESET  = 16'h0000;
    localparam logic [7:0]  KEY_FIRST   = 8'h55;
    localparam logic [7:0]  KEY_SECOND  = 8'hAA;

    // ------------------------------------------------------------
    // Operation codes in the low control bits
    // ------------------------------------------------------------
    localparam logic [6:0]  OP_FLASH_ROW_ERASE = 7'h41;
    localparam logic [6:0]  OP_FLASH_ROW_PROG  = 7'h01;
    localparam logic [6:0]  OP_EE_WORD_ERASE   = 7'h44;
    localparam logic [6:0]  OP_EE_BLOCK_ERASE  = 7'h45;
    localparam logic [6:0]  OP_EE_WORD_PROG    = 7'h04;
    localparam logic [6:0]  OP_EE_BLOCK_PROG   = 7'h05;

    // ------------------------------------------------------------
    // Memory layout and timing
    // ------------------------------------------------------------
    localparam logic [23:0] EE_BASE        = 24'h7FFC00;
    localparam logic [23:0] EE_LAST        = 24'h7FFFFE;
    localparam int          ROW_WORDS      = 32;
    localparam int          EE_BLOCK_WORDS = 16;
    localparam logic [23:0] FLASH_ERASED   = 24'hFFFFFF;
    localparam logic [15:0] EE_ERASED      = 16'hFFFF;
    localparam int          OP_TIME_US     = 2000;
    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          OP_TIME_CYC    = OP_TIME_US * 1000 / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        KEY_IDLE      = 2'b00,
        KEY_GOT_FIRST = 2'b01,
        KEY_ARMED     = 2'b10
    } key_state_t;

endpackage
`default_nettype wire

// ### core/nvm_row_and_eeprom_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_row_and_eeprom_sequencer
    import nvm_seq_pkg::*;
#(
    parameter int FLASH_WORDS = 4096,
    parameter int EE_WORDS    = 512,
    parameter int OP_CYC      = OP_TIME_CYC
)(
    input  wire logic        i_clk_sys,
    input  wire logic        i_srst,
    input  wire logic        i_master_clear_reset,
    input  wire logic        i_watchdog_timer_reset,
    input  wire logic        i_sfr_wr,
    input  wire logic        i_sfr_rd,
    input  wire logic [15:0] i_sfr_addr,
    input  wire logic [15:0] i_sfr_wdata,
    output var  logic [15:0] o_sfr_rdata,
    input  wire logic        i_table_write_low_word,
    input  wire logic        i_table_write_high_byte,
    input  wire logic        i_table_read_op,
    input  wire logic [7:0]  i_table_page_reg,
    input  wire logic [15:0] i_tbl_ea,
    input  wire logic [15:0] i_tbl_wdata,
    output var  logic [23:0] o_tbl_rdata,
    input  wire logic        i_irq_flag_clr,
    output var  logic        o_memory_done_irq_flag,
    output var  logic        o_core_stall
);

    localparam int FW = $clog2(FLASH_WORDS);
    localparam int EW = $clog2(EE_WORDS);

    function automatic logic is_flash_op(input logic [6:0] op);
        is_flash_op = !op[OP_EE_BIT];
    endfunction

    function automatic logic is_ee_addr(input logic [23:0] a);
        is_ee_addr = (a >= EE_BASE) && (a <= EE_LAST);
    endfunction

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic             wr_r;
    logic             write_allow_r;
    logic             write_error_r;
    logic             terminated_r;
    logic [6:0]       op_r;
    logic [15:0]      adr_r;
    logic [7:0]       adru_r;
    key_state_t       key_r;
    logic [31:0]      cnt_r;
    logic [15:0]      latch_lo [ROW_WORDS];
    logic [7:0]       latch_hi [ROW_WORDS];
    logic [23:0]      flash_mem [FLASH_WORDS];
    logic [15:0]      ee_mem [EE_WORDS];

    logic             dev_rst;
    logic             ctrl_wr;
    logic             start;
    logic             op_done;
    logic             tbl_any;
    logic [23:0]      tbl_addr;
    logic [23:0]      tgt_addr;
    logic [4:0]       tbl_slot;

    assign dev_rst  = i_master_clear_reset || i_watchdog_timer_reset;
    assign ctrl_wr  = i_sfr_wr && (i_sfr_addr == ADR_CTRL);
    assign tbl_any  = i_table_write_low_word || i_table_write_high_byte || i_table_read_op;
    assign tbl_addr = {i_table_page_reg, i_tbl_ea};
    assign tgt_addr = {adru_r, adr_r};
    assign tbl_slot = i_tbl_ea[5:1];
    assign start    = ctrl_wr && i_sfr_wdata[BIT_WR] && !wr_r && write_allow_r
                      && (key_r == KEY_ARMED) && !dev_rst;
    assign op_done  = wr_r && (cnt_r == 32'h0000_0000) && !dev_rst;

    // ------------------------------------------------------------
    // Unlock key sequence
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst || dev_rst)
        begin
            key_r <= KEY_IDLE;
        end
        else if (i_sfr_wr)
        begin
            if (i_sfr_addr == ADR_KEY && i_sfr_wdata[7:0] == KEY_FIRST)
            begin
                key_r <= KEY_GOT_FIRST;
            end
            else if (i_sfr_addr == ADR_KEY && i_sfr_wdata[7:0] == KEY_SECOND
                     && key_r == KEY_GOT_FIRST)
            begin
                key_r <= KEY_ARMED;
            end
            else
            begin
                key_r <= KEY_IDLE;
            end
        end
    end

    // ------------------------------------------------------------
    // Control register and operation timer
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            wr_r    <= CTRL_RESET[BIT_WR];
            write_allow_r <= CTRL_RESET[BIT_WRITE_ALLOW];
            write_error_r <= CTRL_RESET[BIT_WRITE_ERROR];
            terminated_r  <= CTRL_RESET[BIT_TERMINATED];
            op_r    <= CTRL_RESET[OP_MSB:0];
        end
        else if (dev_rst)
        begin
            // An interrupted operation leaves the array untouched.
            wr_r <= 1'b0;
            if (wr_r)
            begin
                write_error_r <= 1'b1;
                terminated_r  <= 1'b1;
            end
        end
        else
        begin
            if (ctrl_wr)
            begin
                write_allow_r <= i_sfr_wdata[BIT_WRITE_ALLOW];
                if (!wr_r)
                begin
                    write_error_r <= i_sfr_wdata[BIT_WRITE_ERROR];
                    terminated_r  <= i_sfr_wdata[BIT_TERMINATED];
                    op_r    <= i_sfr_wdata[OP_MSB:0];
                end
            end
            if (start)
            begin
                wr_r <= 1'b1;
            end
            else if (op_done)
            begin
                wr_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            cnt_r <= 32'h0000_0000;
        end
        else if (start)
        begin
            cnt_r <= 32'(OP_CYC - 1);
        end
        else if (wr_r && cnt_r != 32'h0000_0000)
        begin
            cnt_r <= cnt_r - 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // Target address, captured from table instructions or software
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            adr_r  <= ADDR_RESET;
            adru_r <= ADDR_RESET[7:0];
        end
        else if (!wr_r && !dev_rst)
        begin
            if (i_sfr_wr && i_sfr_addr == ADR_LOW)
            begin
                adr_r <= i_sfr_wdata;
            end
            else if (i_sfr_wr && i_sfr_addr == ADR_UPPER)
            begin
                adru_r <= i_sfr_wdata[7:0];
            end
            else if (tbl_any)
            begin
                adr_r  <= i_tbl_ea;
                adru_r <= i_table_page_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // Write latches and arrays
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (i_table_write_low_word)
        begin
            latch_lo[tbl_slot] <= i_tbl_wdata;
        end
        if (i_table_write_high_byte)
        begin
            latch_hi[tbl_slot] <= i_tbl_wdata[7:0];
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (op_done)
        begin
            unique case (op_r)
                OP_FLASH_ROW_ERASE, OP_FLASH_ROW_PROG:
                begin
                    for (int i = 0; i < ROW_WORDS; i++)
                    begin
                        flash_mem[{tgt_addr[FW:6], 5'(i)}] <=
                            op_r[OP_MSB] ? FLASH_ERASED : {latch_hi[i], latch_lo[i]};
                    end
                end
                OP_EE_BLOCK_ERASE, OP_EE_BLOCK_PROG:
                begin
                    for (int i = 0; i < EE_BLOCK_WORDS; i++)
                    begin
                        ee_mem[{tgt_addr[EW:5], 4'(i)}] <=
                            op_r[OP_MSB] ? EE_ERASED : latch_lo[{tgt_addr[5], 4'(i)}];
                    end
                end
                OP_EE_WORD_ERASE:
                begin
                    ee_mem[tgt_addr[EW:1]] <= EE_ERASED;
                end
                OP_EE_WORD_PROG:
                begin
                    ee_mem[tgt_addr[EW:1]] <= latch_lo[tgt_addr[5:1]];
                end
                default:
                begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read paths, stall and completion flag
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            o_tbl_rdata <= 24'h000000;
        end
        else if (i_table_read_op)
        begin
            if (is_ee_addr(tbl_addr))
            begin
                // Data is not defined while the EEPROM is being altered.
                o_tbl_rdata <= (wr_r && !is_flash_op(op_r)) ? 24'h000000
                               : {8'h00, ee_mem[tbl_addr[EW:1]]};
            end
            else if (tbl_addr < 24'(FLASH_WORDS * 2))
            begin
                o_tbl_rdata <= flash_mem[tbl_addr[FW:1]];
            end
            else
            begin
                o_tbl_rdata <= 24'h000000;
            end
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            o_sfr_rdata <= 16'h0000;
        end
        else if (i_sfr_rd)
        begin
            unique case (i_sfr_addr)
                ADR_CTRL:  o_sfr_rdata <= {wr_r, write_allow_r, write_error_r, 4'h0, terminated_r, 1'b0, op_r};
                ADR_LOW:   o_sfr_rdata <= adr_r;
                ADR_UPPER: o_sfr_rdata <= {8'h00, adru_r};
                default:   o_sfr_rdata <= 16'h0000;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst || dev_rst)
        begin
            o_core_stall <= 1'b0;
        end
        else if (start)
        begin
            // The starting write also loads the operation code, so decode the written code.
            o_core_stall <= is_flash_op(i_sfr_wdata[OP_MSB:0]);
        end
        else if (op_done)
        begin
            o_core_stall <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            o_memory_done_irq_flag <= 1'b0;
        end
        else if (op_done)
        begin
            o_memory_done_irq_flag <= 1'b1;
        end
        else if (i_irq_flag_clr)
        begin
            o_memory_done_irq_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_start_needs_key;
        @(posedge i_clk_sys) disable iff (i_srst)
        ctrl_wr && i_sfr_wdata[BIT_WR] && !wr_r && key_r != KEY_ARMED |=> !wr_r;
    endproperty
    a_start_needs_key: assert property (p_start_needs_key) else $error("start taken without key");

    property p_start_needs_allow;
        @(posedge i_clk_sys) disable iff (i_srst)
        ctrl_wr && i_sfr_wdata[BIT_WR] && !wr_r && !write_allow_r |=> !wr_r;
    endproperty
    a_start_needs_allow: assert property (p_start_needs_allow) else $error("start without write allow");

    property p_wr_sticky;
        @(posedge i_clk_sys) disable iff (i_srst)
        wr_r && !op_done && !dev_rst |=> wr_r;
    endproperty
    a_wr_sticky: assert property (p_wr_sticky) else $error("start bit cleared early");

    property p_flash_stall;
        @(posedge i_clk_sys) disable iff (i_srst)
        wr_r && is_flash_op(op_r) |-> o_core_stall;
    endproperty
    a_flash_stall: assert property (p_flash_stall) else $error("core not stalled");

    property p_ee_no_stall;
        @(posedge i_clk_sys) disable iff (i_srst)
        wr_r && !is_flash_op(op_r) |-> !o_core_stall;
    endproperty
    a_ee_no_stall: assert property (p_ee_no_stall) else $error("core stalled by eeprom");

    property p_done_flag;
        @(posedge i_clk_sys) disable iff (i_srst)
        op_done |=> !wr_r && o_memory_done_irq_flag && !o_core_stall;
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("completion not reported");

    property p_reset_error;
        @(posedge i_clk_sys) disable iff (i_srst)
        wr_r && dev_rst |=> write_error_r && !wr_r && $stable(adr_r) && $stable(adru_r);
    endproperty
    a_reset_error: assert property (p_reset_error) else $error("interrupted write not flagged");

    property p_allow_clear_safe;
        @(posedge i_clk_sys) disable iff (i_srst)
        wr_r && ctrl_wr && !i_sfr_wdata[BIT_WRITE_ALLOW] && !op_done && !dev_rst |=> wr_r && $stable(op_r);
    endproperty
    a_allow_clear_safe: assert property (p_allow_clear_safe) else $error("operation altered");

    property p_key_void;
        @(posedge i_clk_sys) disable iff (i_srst)
        key_r == KEY_ARMED && i_sfr_wr && i_sfr_addr != ADR_KEY |=> key_r == KEY_IDLE;
    endproperty
    a_key_void: assert property (p_key_void) else $error("unlock not voided");

    property p_duration;
        @(posedge i_clk_sys) disable iff (i_srst)
        start |=> cnt_r == 32'(OP_CYC - 1) && wr_r;
    endproperty
    a_duration: assert property (p_duration) else $error("timer not loaded");

    property p_capture;
        @(posedge i_clk_sys) disable iff (i_srst)
        tbl_any && !wr_r && !dev_rst && !i_sfr_wr |=> adr_r == $past(i_tbl_ea);
    endproperty
    a_capture: assert property (p_capture) else $error("table address not captured");

endmodule
`default_nettype wire

// ### tb/nvm_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_core_model
    import nvm_seq_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic [15:0] i_sfr_rdata,
    input  wire logic [23:0] i_tbl_rdata,
    output var  logic        o_sfr_wr,
    output var  logic        o_sfr_rd,
    output var  logic [15:0] o_sfr_addr,
    output var  logic [15:0] o_sfr_wdata,
    output var  logic        o_tbl_wl,
    output var  logic        o_tbl_wh,
    output var  logic        o_tbl_rd,
    output var  logic [7:0]  o_page,
    output var  logic [15:0] o_ea,
    output var  logic [15:0] o_tbl_wdata
);
    // ------------------------------------------------------------
    // Core side bus cycles
    // ------------------------------------------------------------
    // Idle address and data other than the page show the inverse of the last value, so a stale bus never reads as valid.
    initial
    begin
        {o_sfr_wr, o_sfr_rd, o_tbl_wl, o_tbl_wh, o_tbl_rd} = 5'h00;
        {o_sfr_addr, o_sfr_wdata, o_page, o_ea, o_tbl_wdata} = 72'h0;
    end

    task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
        @(negedge i_clk_sys);
        o_sfr_addr  = a;
        o_sfr_wdata = d;
        o_sfr_wr    = 1'b1;
        @(negedge i_clk_sys);
        o_sfr_wr    = 1'b0;
        o_sfr_addr  = ~a;
        o_sfr_wdata = ~d;
    endtask

    task automatic reg_read(input logic [15:0] a, output logic [15:0] d);
        @(negedge i_clk_sys);
        o_sfr_addr = a;
        o_sfr_rd   = 1'b1;
        @(negedge i_clk_sys);
        o_sfr_rd   = 1'b0;
        o_sfr_addr = ~a;
        d          = i_sfr_rdata;
    endtask

    // Kind 0 writes a latch low word, 1 a latch high byte, 2 reads the array.
    task automatic tbl_op(input int kind, input logic [7:0] pg, input logic [15:0] ea,
                          input logic [15:0] wd, output logic [23:0] rd);
        @(negedge i_clk_sys);
        o_page      = pg;
        o_ea        = ea;
        o_tbl_wdata = wd;
        o_tbl_wl    = (kind == 0);
        o_tbl_wh    = (kind == 1);
        o_tbl_rd    = (kind == 2);
        @(negedge i_clk_sys);
        {o_tbl_wl, o_tbl_wh, o_tbl_rd} = 3'b000;
        o_ea        = ~ea;
        o_tbl_wdata = ~wd;
        rd          = i_tbl_rdata;
    endtask

    task automatic unlock();
        reg_write(ADR_KEY, 16'h0055);
        reg_write(ADR_KEY, 16'h00AA);
    endtask

    // Write allow goes in an earlier write, then the key, then start, then two idle cycles.
    task automatic start(input logic [6:0] op);
        reg_write(ADR_CTRL, {9'h080, op});
        unlock();
        reg_write(ADR_CTRL, {9'h180, op});
        repeat (2) @(negedge i_clk_sys);
    endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import nvm_seq_pkg::*;
    localparam int OPC = 20;
    logic clk = 1'b0, srst = 1'b1, mcr = 1'b0, wdr = 1'b0, irq_clr = 1'b0;
    logic sfr_wr, sfr_rd, tbl_wl, tbl_wh, tbl_rd, flag, stall;
    logic [15:0] sfr_addr, sfr_wdata, sfr_rdata, ea, tbl_wdata, r;
    logic [7:0]  page;
    logic [23:0] tbl_rdata, t;
    int          n_errors = 0, checks = 0, n;
    int          cyc = 0, t_start = 0;

    always #5 clk = ~clk;

    // Cycle count, and the cycle after the latest control write with the start bit set, whether or not it is taken.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (sfr_wr && sfr_addr == ADR_CTRL && sfr_wdata[BIT_WR])
            t_start <= cyc + 1;
    end

    // A larger array keeps the example row addresses inside program flash.
    nvm_row_and_eeprom_sequencer #(.FLASH_WORDS(16384), .OP_CYC(OPC)) dut_u (
        .i_clk_sys(clk), .i_srst(srst), .i_master_clear_reset(mcr), .i_watchdog_timer_reset(wdr),
        .i_sfr_wr(sfr_wr), .i_sfr_rd(sfr_rd), .i_sfr_addr(sfr_addr), .i_sfr_wdata(sfr_wdata),
        .o_sfr_rdata(sfr_rdata), .i_table_write_low_word(tbl_wl), .i_table_write_high_byte(tbl_wh),
        .i_table_read_op(tbl_rd), .i_table_page_reg(page), .i_tbl_ea(ea), .i_tbl_wdata(tbl_wdata),
        .o_tbl_rdata(tbl_rdata), .i_irq_flag_clr(irq_clr), .o_memory_done_irq_flag(flag),
        .o_core_stall(stall));

    nvm_core_model core_u (
        .i_clk_sys(clk), .i_sfr_rdata(sfr_rdata), .i_tbl_rdata(tbl_rdata), .o_sfr_wr(sfr_wr),
        .o_sfr_rd(sfr_rd), .o_sfr_addr(sfr_addr), .o_sfr_wdata(sfr_wdata), .o_tbl_wl(tbl_wl),
        .o_tbl_wh(tbl_wh), .o_tbl_rd(tbl_rd), .o_page(page), .o_ea(ea), .o_tbl_wdata(tbl_wdata));

    // ------------------------------------------------------------
    // Checking and sequencing helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
        core_u.reg_read(a, r);
        chk({8'h00, r}, {8'h00, exp});
    endtask

    task automatic wait_done();
        n = 0;
        do
        begin
            core_u.reg_read(ADR_CTRL, r);
            n++;
        end
        while (r[BIT_WR] === 1'b1 && n < 200);
        // The clear lands OPC cycles after start; the poll sees it one or two cycles later.
        chk({23'h0, (cyc - t_start > OPC) && (cyc - t_start < OPC + 3)}, 24'h1);
        chk({23'h0, flag}, 24'h1);
        @(negedge clk) irq_clr = 1'b1;
        @(negedge clk) irq_clr = 1'b0;
        chk({23'h0, flag}, 24'h0);
    endtask

    task automatic stop_test();
        if (n_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        stop_test();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge clk);
        @(negedge clk) srst = 1'b0;
        rchk(ADR_CTRL, 16'h0000);
        rchk(ADR_KEY, 16'h0000);
        rchk(16'h0768, 16'h0000);
        core_u.reg_write(ADR_CTRL, 16'h4041);
        core_u.reg_write(ADR_CTRL, 16'hC041);
        rchk(ADR_CTRL, 16'h4041);
        core_u.reg_write(ADR_KEY, 16'h0055);
        core_u.reg_write(ADR_LOW, 16'h1234);
        core_u.reg_write(ADR_KEY, 16'h00AA);
        core_u.reg_write(ADR_CTRL, 16'hC041);
        rchk(ADR_CTRL, 16'h4041);
        core_u.reg_write(ADR_CTRL, 16'h0041);
        core_u.unlock();
        core_u.reg_write(ADR_CTRL, 16'hC041);
        rchk(ADR_CTRL, 16'h4041);
        core_u.tbl_op(2, 8'h00, 16'h6000, 16'h0000, t);
        rchk(ADR_LOW, 16'h6000);
        rchk(ADR_UPPER, 16'h0000);
        for (int i = 0; i < 32; i++)
        begin
            core_u.tbl_op(0, 8'h00, 16'(16'h6000 + 2 * i), 16'(16'hA000 + i), t);
            core_u.tbl_op(1, 8'h00, 16'(16'h6000 + 2 * i), 16'(16'h0040 + i), t);
        end
        core_u.start(OP_FLASH_ROW_PROG);
        chk({23'h0, stall}, 24'h1);
        core_u.reg_write(ADR_CTRL, 16'h0001);
        rchk(ADR_CTRL, 16'h8001);
        wait_done();
        chk({23'h0, stall}, 24'h0);
        for (int i = 0; i < 32; i++)
        begin
            core_u.tbl_op(2, 8'h00, 16'(16'h6000 + 2 * i), 16'h0000, t);
            chk(t, {8'(8'h40 + i), 16'(16'hA000 + i)});
        end
        core_u.reg_write(ADR_LOW, 16'h6040);
        core_u.reg_write(ADR_UPPER, 16'h0000);
        core_u.start(OP_FLASH_ROW_ERASE);
        chk({23'h0, stall}, 24'h1);
        wait_done();
        core_u.tbl_op(2, 8'h00, 16'h6040, 16'h0000, t);
        chk(t, FLASH_ERASED);
        core_u.tbl_op(2, 8'h00, 16'h607E, 16'h0000, t);
        chk(t, FLASH_ERASED);
        core_u.tbl_op(2, 8'h00, 16'h603E, 16'h0000, t);
        chk(t, 24'h5FA01F);
        core_u.tbl_op(2, 8'h01, 16'h0000, 16'h0000, t);
        chk(t, 24'h000000);
        core_u.reg_write(ADR_UPPER, 16'h007F);
        core_u.reg_write(ADR_LOW, 16'hFC10);
        core_u.start(OP_EE_WORD_ERASE);
        chk({23'h0, stall}, 24'h0);
        rchk(ADR_CTRL, 16'hC044);
        core_u.tbl_op(2, 8'h7F, 16'hFC10, 16'h0000, t);
        chk(t, 24'h000000);
        wait_done();
        core_u.tbl_op(0, 8'h7F, 16'hFC10, 16'h1234, t);
        core_u.start(OP_EE_WORD_PROG);
        wait_done();
        core_u.tbl_op(2, 8'h7F, 16'hFC10, 16'h0000, t);
        chk({8'h00, t[15:0]}, 24'h001234);
        core_u.reg_write(ADR_LOW, 16'hFC20);
        core_u.start(OP_EE_BLOCK_ERASE);
        wait_done();
        core_u.tbl_op(2, 8'h7F, 16'hFC3E, 16'h0000, t);
        chk({8'h00, t[15:0]}, {8'h00, EE_ERASED});
        for (int i = 0; i < 16; i++)
            core_u.tbl_op(0, 8'h7F, 16'(16'hFC20 + 2 * i), 16'(16'h5A00 + i), t);
        core_u.start(OP_EE_BLOCK_PROG);
        wait_done();
        for (int i = 0; i < 16; i++)
        begin
            core_u.tbl_op(2, 8'h7F, 16'(16'hFC20 + 2 * i), 16'h0000, t);
            chk({8'h00, t[15:0]}, {8'h00, 16'(16'h5A00 + i)});
        end
        for (int k = 0; k < 2; k++)
        begin
            core_u.reg_write(ADR_UPPER, 16'h0000);
            core_u.reg_write(ADR_LOW, 16'h6080);
            core_u.start(OP_FLASH_ROW_ERASE);
            @(negedge clk)
            begin
                mcr = (k == 0);
                wdr = (k == 1);
            end
            @(negedge clk)
            begin
                mcr = 1'b0;
                wdr = 1'b0;
            end
            chk({23'h0, stall}, 24'h0);
            rchk(ADR_CTRL, 16'h6141);
            rchk(ADR_LOW, 16'h6080);
        end
        stop_test();
    end
endmodule
`default_nettype wire
